// *** hw/bctc_led_blinker.sv ***
// run indicator pattern generator driven by a cycle divider
`timescale 1ns/1ps
module bctc_led_blinker #(
    parameter int SLOW_HALF = bctc_pkg::LED_SLOW_HALF,
    parameter int FAST_HALF = bctc_pkg::LED_FAST_HALF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire bctc_pkg::bctc_led_type led_mode,
    output logic run_led
);
    // divider count, wide enough for the slow half period
    logic [31:0] div_q;
    // last pattern, to restart the divider on a change
    bctc_pkg::bctc_led_type mode_q;
    logic [31:0] half_lim;
    // half period of the current flashing pattern
    always_comb begin
        half_lim = (led_mode == bctc_pkg::LED_FAST) ? 32'(FAST_HALF) : 32'(SLOW_HALF);
    end
    // divider counts up to the half period and restarts on pattern change
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_q <= 32'h0;
            mode_q <= bctc_pkg::LED_OFF;
        end else begin
            mode_q <= led_mode;
            if (mode_q != led_mode || div_q >= half_lim - 32'h1) begin
                div_q <= 32'h0;
            end else begin
                div_q <= div_q + 32'h1;
            end
        end
    end
    // indicator toggles on each half period end, solid or dark otherwise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            run_led <= 1'b0;
        end else begin
            case (led_mode)
                bctc_pkg::LED_SOLID: run_led <= 1'b1;
                bctc_pkg::LED_SLOW, bctc_pkg::LED_FAST: begin
                    if (mode_q != led_mode) begin
                        run_led <= 1'b1;
                    end else if (div_q >= half_lim - 32'h1) begin
                        run_led <= ~run_led;
                    end
                end
                default: run_led <= 1'b0;
            endcase
        end
    end
endmodule

// *** hw/bctc_transfer_ctrl.sv ***
// backup card transfer sequencer with bank storage and error checks
`timescale 1ns/1ps
module bctc_transfer_ctrl #(
    parameter int BANK_WORDS = bctc_pkg::BANK_WORDS,
    parameter int DATA_W = bctc_pkg::DATA_W,
    parameter int PREP_CYCLES = bctc_pkg::PREP_CYCLES,
    parameter int LED_SLOW_HALF = bctc_pkg::LED_SLOW_HALF,
    parameter int LED_FAST_HALF = bctc_pkg::LED_FAST_HALF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire bctc_pkg::bctc_sw_type sw_in,
    input wire logic sysprog_capable,
    input wire logic man_start,
    input wire logic man_dir,
    input wire logic man_bank,
    input wire logic term_rd_valid,
    input wire logic [DATA_W-1:0] term_rd_data,
    input wire logic term_wr_ready,
    output logic term_rd_req,
    output logic term_wr_valid,
    output logic [DATA_W-1:0] term_wr_data,
    output logic [$clog2(BANK_WORDS)-1:0] term_addr,
    output logic term_area,
    output bctc_pkg::bctc_err_type err_flags,
    output logic busy,
    output logic done,
    output logic operating_inhibit,
    output logic run_led
);
    localparam int AW = $clog2(BANK_WORDS);
    localparam logic [AW-1:0] LAST_ADDR = AW'(BANK_WORDS - 1);
    localparam logic [7:0] PREP_LAST = 8'(PREP_CYCLES - 1);

    // switches frozen at startup
    bctc_pkg::bctc_sw_type sw_q;
    // sequencer phase
    bctc_pkg::bctc_phase_type phase_q;
    // plan of the current pass
    logic dir_q;
    logic bank_q;
    logic kind_q;
    logic pass_q;
    // word address and preparation count
    logic [AW-1:0] addr_q;
    logic [7:0] prep_q;
    // a read request is outstanding towards the terminal
    logic wait_q;
    // card storage: both banks in one array, bank is the top index bit
    logic [DATA_W-1:0] mem_q [0:2*BANK_WORDS-1];
    // content kind held by each bank
    logic [1:0] tag_q;
    // indicator pattern
    bctc_pkg::bctc_led_type led_q;
    // card write strobe and address
    logic mem_we;
    logic [AW:0] mem_wa;
    logic [DATA_W-1:0] mem_rd;
    logic mode_bad;

    // checks one planned transfer, returns protect and data error bits
    function automatic logic [1:0] plan_errors(input bctc_pkg::bctc_sw_type sw,
            input logic dir, input logic bank, input logic [1:0] tags, input logic capable);
        logic prot;
        logic data;
        prot = 1'b0;
        data = 1'b0;
        // destination permit must be on
        if (dir == bctc_pkg::DIR_TO_TERMINAL && !sw.terminal_write_permit) begin
            prot = 1'b1;
        end
        if (dir == bctc_pkg::DIR_TO_CARD && !sw.card_write_permit) begin
            prot = 1'b1;
        end
        // system program needs the capable variant
        if ((sw.combined_transfer_en || sw.content_kind_sel == bctc_pkg::KIND_SYSTEM)
                && !capable) begin
            data = 1'b1;
        end
        // stored kind must match the terminal area it goes to
        if (dir == bctc_pkg::DIR_TO_TERMINAL) begin
            if (sw.combined_transfer_en) begin
                if (tags[bctc_pkg::BANK_FIRST] != bctc_pkg::KIND_SYSTEM) begin
                    data = 1'b1;
                end
                if (tags[bctc_pkg::BANK_SECOND] != bctc_pkg::KIND_SCREEN) begin
                    data = 1'b1;
                end
            end else if (tags[bank] != sw.content_kind_sel) begin
                data = 1'b1;
            end
        end
        return {prot, data};
    endfunction

    // exactly one of the three mode switches must be on
    always_comb begin
        mode_bad = (32'(sw_q.auto_card_to_terminal_sel) + 32'(sw_q.auto_terminal_to_card_sel)
            + 32'(sw_q.manual_transfer_sel)) != 32'd1;
    end

    // card write happens when a terminal word arrives during a card fill
    always_comb begin
        mem_we = (phase_q == bctc_pkg::PH_XFER) && dir_q == bctc_pkg::DIR_TO_CARD
            && wait_q && term_rd_valid;
        mem_wa = {bank_q, addr_q};
        mem_rd = mem_q[{bank_q, addr_q}];
    end

    // switches caught once after reset release, held until next startup
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sw_q <= bctc_pkg::SW_DEFAULT;
        end else if (phase_q == bctc_pkg::PH_SAMPLE) begin
            sw_q <= sw_in;
        end
    end

    // main sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            phase_q <= bctc_pkg::PH_SAMPLE;
            dir_q <= bctc_pkg::DIR_TO_TERMINAL;
            bank_q <= bctc_pkg::BANK_FIRST;
            kind_q <= bctc_pkg::KIND_SCREEN;
            pass_q <= 1'b0;
            err_flags <= bctc_pkg::ERR_NONE;
        end else begin
            case (phase_q)
                bctc_pkg::PH_SAMPLE: phase_q <= bctc_pkg::PH_CHECK;
                bctc_pkg::PH_CHECK: begin
                    // combined mode pins kinds and banks to the first pass
                    kind_q <= sw_q.combined_transfer_en ? bctc_pkg::KIND_SYSTEM
                        : sw_q.content_kind_sel;
                    bank_q <= sw_q.combined_transfer_en ? bctc_pkg::BANK_FIRST
                        : sw_q.bank_sel;
                    dir_q <= sw_q.auto_terminal_to_card_sel ? bctc_pkg::DIR_TO_CARD
                        : bctc_pkg::DIR_TO_TERMINAL;
                    if (mode_bad) begin
                        err_flags.mode_err <= 1'b1;
                        phase_q <= bctc_pkg::PH_FAULT;
                    end else if (sw_q.manual_transfer_sel) begin
                        phase_q <= bctc_pkg::PH_MANWAIT;
                    end else if (|plan_errors(sw_q, sw_q.auto_terminal_to_card_sel,
                            sw_q.bank_sel, tag_q, sysprog_capable)) begin
                        // the sysprog_capable input still takes part for card fills
                        {err_flags.protect_err, err_flags.data_err} <= plan_errors(sw_q,
                            sw_q.auto_terminal_to_card_sel, sw_q.bank_sel, tag_q,
                            sysprog_capable);
                        phase_q <= bctc_pkg::PH_FAULT;
                    end else begin
                        phase_q <= bctc_pkg::PH_PREP;
                    end
                end
                bctc_pkg::PH_MANWAIT: begin
                    // panel chooses direction, and bank outside combined mode
                    if (man_start) begin
                        dir_q <= man_dir;
                        bank_q <= sw_q.combined_transfer_en ? bctc_pkg::BANK_FIRST : man_bank;
                        if (|plan_errors(sw_q, man_dir, man_bank, tag_q, sysprog_capable)) begin
                            {err_flags.protect_err, err_flags.data_err} <= plan_errors(sw_q,
                                man_dir, man_bank, tag_q, sysprog_capable);
                            phase_q <= bctc_pkg::PH_FAULT;
                        end else begin
                            phase_q <= bctc_pkg::PH_PREP;
                        end
                    end
                end
                bctc_pkg::PH_PREP: begin
                    if (prep_q == PREP_LAST) begin
                        phase_q <= bctc_pkg::PH_XFER;
                    end
                end
                bctc_pkg::PH_XFER: begin
                    if (addr_q == LAST_ADDR && (mem_we || (term_wr_valid && term_wr_ready))) begin
                        phase_q <= bctc_pkg::PH_VERIFY;
                    end
                end
                bctc_pkg::PH_VERIFY: begin
                    if (wait_q && term_rd_valid) begin
                        if (term_rd_data != mem_rd) begin
                            err_flags.verify_err <= 1'b1;
                            phase_q <= bctc_pkg::PH_FAULT;
                        end else if (addr_q == LAST_ADDR) begin
                            if (sw_q.combined_transfer_en && !pass_q) begin
                                // second pass: screen data into the second bank
                                pass_q <= 1'b1;
                                kind_q <= bctc_pkg::KIND_SCREEN;
                                bank_q <= bctc_pkg::BANK_SECOND;
                                phase_q <= bctc_pkg::PH_XFER;
                            end else begin
                                phase_q <= bctc_pkg::PH_DONE;
                            end
                        end
                    end
                end
                bctc_pkg::PH_DONE: phase_q <= bctc_pkg::PH_DONE;
                bctc_pkg::PH_FAULT: phase_q <= bctc_pkg::PH_FAULT;
                default: phase_q <= bctc_pkg::PH_FAULT;
            endcase
        end
    end

    // preparation count
    always_ff @(posedge core_clk) begin
        if (!rst_n || phase_q != bctc_pkg::PH_PREP) begin
            prep_q <= 8'h00;
        end else begin
            prep_q <= prep_q + 8'h01;
        end
    end

    // word address walks each bank, restarts per step
    always_ff @(posedge core_clk) begin
        if (!rst_n || (phase_q != bctc_pkg::PH_XFER && phase_q != bctc_pkg::PH_VERIFY)) begin
            addr_q <= '0;
        end else if (mem_we || (term_wr_valid && term_wr_ready)
                || (phase_q == bctc_pkg::PH_VERIFY && wait_q && term_rd_valid)) begin
            addr_q <= (addr_q == LAST_ADDR) ? '0 : addr_q + AW'(1);
        end
    end

    // terminal read requests for card fills and verification
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            term_rd_req <= 1'b0;
            wait_q <= 1'b0;
        end else begin
            term_rd_req <= 1'b0;
            if (wait_q && term_rd_valid) begin
                wait_q <= 1'b0;
            end else if (!wait_q && !term_rd_req && (phase_q == bctc_pkg::PH_VERIFY
                    || (phase_q == bctc_pkg::PH_XFER && dir_q == bctc_pkg::DIR_TO_CARD))) begin
                term_rd_req <= 1'b1;
                wait_q <= 1'b1;
            end
        end
    end

    // words offered to the terminal, held until accepted
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            term_wr_valid <= 1'b0;
            term_wr_data <= '0;
        end else if (term_wr_valid) begin
            if (term_wr_ready) begin
                term_wr_valid <= 1'b0;
            end
        end else if (phase_q == bctc_pkg::PH_XFER && dir_q == bctc_pkg::DIR_TO_TERMINAL) begin
            term_wr_valid <= 1'b1;
            term_wr_data <= mem_rd;
        end
    end

    // card storage write, addressed bank only, keeps no reset
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem_q[mem_wa] <= term_rd_data;
        end
    end

    // bank kind tags, updated when a fill of that bank completes
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tag_q <= 2'h0;
        end else if (mem_we && addr_q == LAST_ADDR) begin
            tag_q[bank_q] <= kind_q;
        end
    end

    // status outputs, indicator pattern and operating hold-off
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            term_addr <= '0;
            term_area <= bctc_pkg::KIND_SCREEN;
            busy <= 1'b0;
            done <= 1'b0;
            operating_inhibit <= 1'b1;
            led_q <= bctc_pkg::LED_OFF;
        end else begin
            term_addr <= addr_q;
            term_area <= kind_q;
            busy <= phase_q == bctc_pkg::PH_PREP || phase_q == bctc_pkg::PH_XFER
                || phase_q == bctc_pkg::PH_VERIFY;
            done <= phase_q == bctc_pkg::PH_DONE;
            operating_inhibit <= 1'b1;
            case (phase_q)
                bctc_pkg::PH_PREP: led_q <= bctc_pkg::LED_SLOW;
                bctc_pkg::PH_XFER, bctc_pkg::PH_VERIFY: led_q <= bctc_pkg::LED_FAST;
                bctc_pkg::PH_DONE: led_q <= bctc_pkg::LED_SOLID;
                default: led_q <= bctc_pkg::LED_OFF;
            endcase
        end
    end

    // run indicator pattern generator
    bctc_led_blinker #(
        .SLOW_HALF(LED_SLOW_HALF),
        .FAST_HALF(LED_FAST_HALF)
    ) u_led (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .led_mode(led_q),
        .run_led(run_led)
    );

    // a finished fill of the last word leads to verification next
    sequence s_last_fill;
        phase_q == bctc_pkg::PH_XFER && mem_we && addr_q == LAST_ADDR;
    endsequence
    sequence s_done_hold;
        (phase_q == bctc_pkg::PH_DONE) [*3];
    endsequence

    chk_switch_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
        phase_q != bctc_pkg::PH_SAMPLE && $past(phase_q) != bctc_pkg::PH_SAMPLE
            |-> $stable(sw_q))
        else $error("switches changed after startup");
    chk_mode_error: assert property (@(posedge core_clk) disable iff (!rst_n)
        phase_q == bctc_pkg::PH_CHECK && mode_bad
            |=> phase_q == bctc_pkg::PH_FAULT && err_flags.mode_err)
        else $error("mode error not raised");
    chk_term_permit: assert property (@(posedge core_clk) disable iff (!rst_n)
        term_wr_valid |-> sw_q.terminal_write_permit)
        else $error("terminal written without permit");
    chk_card_permit: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_we |-> sw_q.card_write_permit && dir_q == bctc_pkg::DIR_TO_CARD)
        else $error("card written without permit");
    chk_no_write_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        (err_flags.mode_err || err_flags.protect_err || err_flags.data_err)
            |-> !mem_we && !term_wr_valid)
        else $error("write after error");
    chk_combined_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
        sw_q.combined_transfer_en && phase_q == bctc_pkg::PH_XFER
            |-> bank_q == pass_q && kind_q == !pass_q)
        else $error("combined pass uses wrong bank");
    chk_variant_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        phase_q == bctc_pkg::PH_XFER && kind_q == bctc_pkg::KIND_SYSTEM |-> sysprog_capable)
        else $error("system program on plain variant");
    chk_fill_verify: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_last_fill |=> phase_q == bctc_pkg::PH_VERIFY ##1 tag_q[bank_q] == kind_q)
        else $error("fill end not followed by verify");
    chk_done_led: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_done_hold |-> run_led && done)
        else $error("indicator not solid when finished");
    chk_hold_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        operating_inhibit)
        else $error("terminal released while attached");
endmodule

// *** shared/bctc_pkg.sv ***
// constants, carrier types and the overview for the backup card transfer controller
package bctc_pkg;
    // eight configuration switches, one packed carrier
    typedef struct packed {
        logic auto_card_to_terminal_sel;
        logic auto_terminal_to_card_sel;
        logic manual_transfer_sel;
        logic content_kind_sel;
        logic terminal_write_permit;
        logic card_write_permit;
        logic bank_sel;
        logic combined_transfer_en;
    } bctc_sw_type;
    // delivered state of all switches
    localparam bctc_sw_type SW_DEFAULT = 8'h00;
    // content kinds double as the terminal area code
    localparam logic KIND_SCREEN = 1'b0;
    localparam logic KIND_SYSTEM = 1'b1;
    // bank codes
    localparam logic BANK_FIRST = 1'b0;
    localparam logic BANK_SECOND = 1'b1;
    // transfer direction codes
    localparam logic DIR_TO_TERMINAL = 1'b0;
    localparam logic DIR_TO_CARD = 1'b1;
    // storage geometry
    localparam int DATA_W = 8;
    localparam int BANK_WORDS = 1024;
    // timing: clock rate and indicator periods in their own units
    localparam longint CLK_HZ = 200000000;
    localparam longint LED_SLOW_PERIOD_MS = 1000;
    localparam longint LED_FAST_PERIOD_MS = 500;
    localparam int LED_SLOW_HALF = int'(CLK_HZ * LED_SLOW_PERIOD_MS / 1000 / 2);
    localparam int LED_FAST_HALF = int'(CLK_HZ * LED_FAST_PERIOD_MS / 1000 / 2);
    // preparation hold in cycles
    localparam int PREP_CYCLES = 16;
    // sequencer phases, one-hot
    typedef enum logic [7:0] {
        PH_SAMPLE = 8'h01,
        PH_CHECK = 8'h02,
        PH_MANWAIT = 8'h04,
        PH_PREP = 8'h08,
        PH_XFER = 8'h10,
        PH_VERIFY = 8'h20,
        PH_DONE = 8'h40,
        PH_FAULT = 8'h80
    } bctc_phase_type;
    // indicator patterns
    typedef enum logic [3:0] {
        LED_OFF = 4'h1,
        LED_SLOW = 4'h2,
        LED_FAST = 4'h4,
        LED_SOLID = 4'h8
    } bctc_led_type;
    // error report carrier
    typedef struct packed {
        logic mode_err;
        logic protect_err;
        logic data_err;
        logic verify_err;
    } bctc_err_type;
    localparam bctc_err_type ERR_NONE = 4'h0;
endpackage

// *** sim/bctc_term_model.sv ***
// terminal side model answering the card controller's read and write channels
`timescale 1ns/1ps
module bctc_term_model (
    input wire logic core_clk,
    input wire logic load,
    input wire logic [7:0] seed,
    input wire logic term_rd_req,
    input wire logic [2:0] term_addr,
    input wire logic term_area,
    input wire logic term_wr_valid,
    input wire logic [7:0] term_wr_data,
    output logic term_rd_valid,
    output logic [7:0] term_rd_data,
    output logic term_wr_ready,
    output int wr_count
);
    logic [7:0] mem [2][8]; // screen and system areas
    logic [1:0] cnt_q = 2'h0; // answer delay countdown
    logic slow_q = 1'b0; // alternates prompt and slow answers
    logic [1:0] stall_q = 2'h0; // write stall pattern
    initial begin
        term_rd_valid = 1'b0;
        term_rd_data = 8'h00;
        term_wr_ready = 1'b0;
        wr_count = 0;
    end
    // answer reads, take writes, reload content on request
    always @(posedge core_clk) begin
        stall_q <= stall_q + 2'h1;
        term_wr_ready <= stall_q[1]; // stalls half of the time
        term_rd_valid <= 1'b0;
        term_rd_data <= ~term_rd_data; // no stale value outside an answer
        if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end
        if (term_rd_req) begin
            cnt_q <= slow_q ? 2'h3 : 2'h1;
            slow_q <= ~slow_q;
        end
        if (cnt_q == 2'h1) begin
            term_rd_valid <= 1'b1;
            term_rd_data <= mem[term_area][term_addr];
        end
        if (term_wr_valid && term_wr_ready) begin
            mem[term_area][term_addr] <= term_wr_data;
            wr_count <= wr_count + 1;
        end
        if (load) begin
            for (int a = 0; a < 2; a++) begin
                for (int i = 0; i < 8; i++) begin
                    mem[a][i] <= seed ^ 8'(i) ^ {a[0], 7'h00};
                end
            end
        end
    end
endmodule

// *** sim/test_bctc_transfer_ctrl.sv ***
// self-checking bench for the backup card transfer controller
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module test_bctc_transfer_ctrl;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    bctc_pkg::bctc_sw_type sw_in = bctc_pkg::SW_DEFAULT;
    logic sysprog_capable = 1'b0;
    logic man_start = 1'b0;
    logic man_dir = 1'b0;
    logic man_bank = 1'b0;
    logic term_rd_valid, term_rd_req, term_wr_valid, term_wr_ready, term_area;
    logic [7:0] term_rd_data, term_wr_data;
    logic [2:0] term_addr;
    bctc_pkg::bctc_err_type err_flags;
    logic busy, done, operating_inhibit, run_led;
    logic load = 1'b0;
    logic [7:0] seed = 8'h00;
    int wr_count, err_total = 0, tests_run = 0, tnum = 0;
    always #2.5 core_clk = ~core_clk;
    bctc_transfer_ctrl #(.BANK_WORDS(8), .DATA_W(8), .PREP_CYCLES(4), .LED_SLOW_HALF(8),
        .LED_FAST_HALF(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .sw_in(sw_in),
        .sysprog_capable(sysprog_capable), .man_start(man_start), .man_dir(man_dir),
        .man_bank(man_bank), .term_rd_valid(term_rd_valid), .term_rd_data(term_rd_data),
        .term_wr_ready(term_wr_ready), .term_rd_req(term_rd_req),
        .term_wr_valid(term_wr_valid), .term_wr_data(term_wr_data), .term_addr(term_addr),
        .term_area(term_area), .err_flags(err_flags), .busy(busy), .done(done),
        .operating_inhibit(operating_inhibit), .run_led(run_led));
    bctc_term_model tm (.core_clk(core_clk), .load(load), .seed(seed),
        .term_rd_req(term_rd_req), .term_addr(term_addr), .term_area(term_area),
        .term_wr_valid(term_wr_valid), .term_wr_data(term_wr_data),
        .term_rd_valid(term_rd_valid), .term_rd_data(term_rd_data),
        .term_wr_ready(term_wr_ready), .wr_count(wr_count));
    // reload terminal content from a seed
    task reload(input logic [7:0] s);
        @(posedge core_clk) #1 seed = s;
        load = 1'b1;
        @(posedge core_clk) #1 load = 1'b0;
    endtask
    // one startup: reset with switches, wait for finish or fault, check outcome
    task run(input logic [7:0] s, input logic cap, input logic [3:0] e_err, input int e_wr,
        input logic [1:0] man);
        int n0;
        n0 = wr_count;
        tnum++;
        @(posedge core_clk) #1 rst_n = 1'b0;
        sw_in = s;
        sysprog_capable = cap;
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 sw_in = bctc_pkg::SW_DEFAULT; // late change must be ignored
        if (man[0]) begin
            // upper bit picks a copy into the terminal from the panel
            man_dir = man[1] ? bctc_pkg::DIR_TO_TERMINAL : bctc_pkg::DIR_TO_CARD;
            man_bank = bctc_pkg::BANK_SECOND;
            man_start = 1'b1;
            @(posedge core_clk) #1 man_start = 1'b0;
        end
        for (int i = 0; i < 3000 && done !== 1'b1 && err_flags === 4'h0; i++) begin
            @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
        #1;
        `CHK(err_flags, e_err)
        `CHK(busy, 1'b0)
        `CHK(done, (e_err == 4'h0))
        `CHK(run_led, (e_err == 4'h0))
        `CHK(operating_inhibit, 1'b1)
        `CHK(wr_count - n0, e_wr)
        $display("test %0d ended", tnum);
    endtask
    // terminal content after a copy into it
    task memcheck(input logic [7:0] s);
        for (int i = 0; i < 8; i++) begin
            `CHK(tm.mem[0][i], s ^ 8'(i))
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        final_report();
    end
    initial begin
        run(8'h00, 1'b0, 4'h8, 0, 1'b0);
        run(8'hCC, 1'b1, 4'h8, 0, 1'b0);
        reload(8'h10);
        run(8'h44, 1'b0, 4'h0, 0, 1'b0);
        reload(8'h50);
        run(8'h46, 1'b0, 4'h0, 0, 1'b0);
        run(8'h40, 1'b0, 4'h4, 0, 1'b0);
        reload(8'hA0);
        run(8'h88, 1'b0, 4'h0, 8, 1'b0);
        memcheck(8'h10);
        run(8'h8A, 1'b0, 4'h0, 8, 1'b0);
        memcheck(8'h50);
        run(8'h80, 1'b0, 4'h4, 0, 1'b0);
        run(8'h98, 1'b1, 4'h2, 0, 1'b0);
        run(8'h54, 1'b0, 4'h2, 0, 1'b0);
        run(8'h45, 1'b1, 4'h0, 0, 1'b0);
        run(8'h89, 1'b1, 4'h2, 0, 1'b0);
        run(8'h24, 1'b0, 4'h0, 0, 2'b01);
        reload(8'h33);
        run(8'h28, 1'b0, 4'h0, 8, 2'b11);
        memcheck(8'h50);
        final_report();
    end
endmodule
